// ==== inc/psc_pkg.sv ====
// Shared constants and types for the program counter, stack and status core
package psc_pkg;

	// Widths and depths
	localparam int PC_W        = 13;
	localparam int STACK_DEPTH = 8;
	localparam int PTR_W       = 3;
	localparam int IDX_W       = 8;
	localparam int JMP_W       = 11;

	// Register indexes in data space; byte address is four times the index
	localparam logic [IDX_W-1:0] STATUS_IDX        = 8'h03;
	localparam logic [IDX_W-1:0] STATUS_MIRROR_IDX = 8'h83;
	localparam logic [IDX_W-1:0] PCL_IDX           = 8'h02;
	localparam logic [IDX_W-1:0] PCL_MIRROR_IDX    = 8'h82;
	localparam logic [IDX_W-1:0] PC_HIGH_LATCH_IDX        = 8'h0A;
	localparam logic [IDX_W-1:0] PC_HIGH_LATCH_MIRROR_IDX = 8'h8A;

	// Status field positions
	localparam int ST_IRP = 7;
	localparam int ST_RP1 = 6;
	localparam int ST_RP0 = 5;
	localparam int ST_TO  = 4;
	localparam int ST_PD  = 3;
	localparam int ST_Z   = 2;
	localparam int ST_DC  = 1;
	localparam int ST_C   = 0;

	// Values after reset
	localparam logic [7:0]      STATUS_RST = 8'h18;
	localparam logic [4:0]      PC_HIGH_LATCH_RST = 5'h00;
	localparam logic [PC_W-1:0] PC_RST     = 13'h0000;

	// Interrupt vector
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

	// Bus answer latency in cycles from request to ack
	localparam int ACK_LAT = 1;

	// Source of the next program counter value
	typedef enum logic [2:0] {
		PSC_SRC_HOLD,
		PSC_SRC_IRQ,
		PSC_SRC_CALL,
		PSC_SRC_JUMP,
		PSC_SRC_POP,
		PSC_SRC_PCLW,
		PSC_SRC_INC
	} psc_pc_src_type;

endpackage

// ==== design/psc_ret_stack.sv ====
// Eight-entry circular return address stack
`timescale 1ns/1ps
module psc_ret_stack (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// Push and pop requests
	input  wire logic                    push,
	input  wire logic                    pop,
	input  wire logic [psc_pkg::PC_W-1:0] push_data,
	// Entry that a pop returns
	output logic      [psc_pkg::PC_W-1:0] top_data
);

	logic [psc_pkg::PC_W-1:0]  ent_q [psc_pkg::STACK_DEPTH];
	logic [psc_pkg::PTR_W-1:0] ptr_q;

	// Entry storage, written at the pointer on a push
	for (genvar g = 0; g < psc_pkg::STACK_DEPTH; g++) begin : g_ent
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				ent_q[g] <= psc_pkg::PC_RST;
			end else if (push && ptr_q == psc_pkg::PTR_W'(g)) begin
				ent_q[g] <= push_data;
			end
		end
	end

	// Pointer wraps silently; no overflow or underflow flag exists
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= '0;
		end else if (push) begin
			ptr_q <= ptr_q + 3'h1;
		end else if (pop) begin
			ptr_q <= ptr_q - 3'h1;
		end
	end

	// Last pushed entry
	assign top_data = ent_q[ptr_q - 3'h1];

	a_push_stores: assert property (@(posedge clk) disable iff (!rst_n)
		push |=> ent_q[$past(ptr_q)] == $past(push_data))
		else $error("push did not store data at pointer");

	a_ptr_wraps: assert property (@(posedge clk) disable iff (!rst_n)
		push && ptr_q == 3'h7 |=> ptr_q == 3'h0)
		else $error("stack pointer did not wrap");

endmodule

// ==== design/psc_status_reg.sv ====
// Status register with arithmetic, reset-cause and bank-select bits
`timescale 1ns/1ps
module psc_status_reg (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Software write
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// Arithmetic flag update
	input  wire logic       alu_en,
	input  wire logic       alu_sub,
	input  wire logic [7:0] alu_a,
	input  wire logic [7:0] alu_b,
	// Reset-cause events
	input  wire logic       wdt_kick,
	input  wire logic       halt,
	input  wire logic       wdt_timeout,
	// Register value
	output logic      [7:0] status_q
);

	logic [7:0] b_eff;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] status_d;

	// Subtraction adds the two's complement, so carries read as not-borrow
	always_comb begin
		b_eff = alu_sub ? ~alu_b : alu_b;
		sum9  = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_sub};
		nib5  = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub};
	end

	// Next value: write, then flag override, then reset-cause events
	always_comb begin
		status_d = status_q;
		if (wr_en) begin
			status_d[psc_pkg::ST_IRP:psc_pkg::ST_RP0] = wr_data[7:5];
			status_d[psc_pkg::ST_Z:psc_pkg::ST_C]     = wr_data[2:0];
		end
		if (alu_en) begin
			status_d[psc_pkg::ST_Z]  = (sum9[7:0] == 8'h00);
			status_d[psc_pkg::ST_DC] = nib5[4];
			status_d[psc_pkg::ST_C]  = sum9[8];
		end
		if (wdt_kick) begin
			status_d[psc_pkg::ST_TO] = 1'b1;
			status_d[psc_pkg::ST_PD] = 1'b1;
		end
		if (halt) begin
			status_d[psc_pkg::ST_TO] = 1'b1;
			status_d[psc_pkg::ST_PD] = 1'b0;
		end
		if (wdt_timeout) begin
			status_d[psc_pkg::ST_TO] = 1'b0;
		end
	end

	// Power-up sets both reset-cause flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= psc_pkg::STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	a_cause_read_only: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && !wdt_kick && !halt && !wdt_timeout
		|=> $stable(status_q[psc_pkg::ST_TO:psc_pkg::ST_PD]))
		else $error("software write changed reset-cause flags");

	a_alu_carry_wins: assert property (@(posedge clk) disable iff (!rst_n)
		alu_en |=> status_q[psc_pkg::ST_C] == $past(sum9[8])
			&& status_q[psc_pkg::ST_Z] == ($past(sum9[7:0]) == 8'h00))
		else $error("arithmetic flags not taken from result");

	a_halt_flags: assert property (@(posedge clk) disable iff (!rst_n)
		halt && !wdt_kick && !wdt_timeout
		|=> status_q[psc_pkg::ST_TO] && !status_q[psc_pkg::ST_PD])
		else $error("halt did not set expiry and clear sleep flag");

endmodule

// ==== design/psc_core.sv ====
// Program counter, high latch, return stack and status core
//
// Summary of operation
// - Flag-updating instruction overrides written flag bits
// - Expiry and sleep flags ignore software writes
// - Status register visible at 03H and 83H
// - Expiry flag: set power-up/kick/halt, timeout clears
// - Sleep flag: set power-up/kick, halt clears
// - Carry flag reports carry out of MSB
// - Subtraction carries act as active-low borrows
// - Thirteen-bit counter, upper bits from latch
// - Low-byte write loads upper bits from latch
// - Jumps take bits 12:11 from latch
// - Every reset clears the program counter
// - Eight by thirteen hidden return stack
// - Calls and interrupts push the counter
// - Returns and interrupt exit pop the counter
// - Push and pop leave latch unchanged
// - Stack wraps, ninth push overwrites first
// - No overflow or underflow indication
// - Interrupt clears enable, pushes, vectors 0004h
`timescale 1ns/1ps
module psc_core (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// Non-power-up reset pulse from the reset circuitry
	input  wire logic                    core_reset,
	// Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [9:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	// Instruction events from the decoder
	input  wire logic                    pc_advance,
	input  wire logic                    instr_call,
	input  wire logic                    direct_jump_instr,
	input  wire logic [psc_pkg::JMP_W-1:0] jump_addr,
	input  wire logic                    instr_return,
	input  wire logic                    exit_with_literal_instr,
	input  wire logic                    interrupt_exit_instr,
	input  wire logic                    irq_take,
	// Arithmetic flag update
	input  wire logic                    alu_flag_en,
	input  wire logic                    alu_sub,
	input  wire logic [7:0]              alu_a,
	input  wire logic [7:0]              alu_b,
	// Reset-cause events
	input  wire logic                    watchdog_kick_instr,
	input  wire logic                    halt_instr,
	input  wire logic                    watchdog_timeout,
	// Direct data addressing
	input  wire logic [6:0]              direct_addr,
	output logic      [7:0]              bank_addr,
	// Core state
	output logic      [psc_pkg::PC_W-1:0] pc,
	output logic      [7:0]              status,
	output logic      [7:0]              pc_high_latch,
	output logic                         global_irq_enable_clr,
	output logic                         global_irq_enable_set
);

	logic [psc_pkg::PC_W-1:0] pc_q;
	logic [psc_pkg::PC_W-1:0] pc_d;
	logic [4:0]               pc_high_latch_q;
	logic [psc_pkg::PC_W-1:0] stack_top;
	logic [7:0]               status_q;
	logic [31:0]              dat_q;
	logic                     ack_q;
	logic                     gie_clr_q;
	logic                     gie_set_q;
	logic [psc_pkg::IDX_W-1:0] bus_idx;
	logic                     bus_req;
	logic                     bus_wr;
	logic                     pcl_wr;
	logic                     pc_high_latch_wr;
	logic                     status_wr;
	logic                     any_pop;
	logic                     push;
	logic [7:0]               rd_byte;
	psc_pkg::psc_pc_src_type  pc_src;

	// Status lives at both bank images of one index
	function automatic logic is_status(input logic [7:0] idx);
		return idx == psc_pkg::STATUS_IDX
			|| idx == psc_pkg::STATUS_MIRROR_IDX;
	endfunction

	// Counter low byte, mirrored in both banks
	function automatic logic is_pcl(input logic [7:0] idx);
		return idx == psc_pkg::PCL_IDX || idx == psc_pkg::PCL_MIRROR_IDX;
	endfunction

	// High latch, mirrored in both banks
	function automatic logic is_pc_high_latch(input logic [7:0] idx);
		return idx == psc_pkg::PC_HIGH_LATCH_IDX
			|| idx == psc_pkg::PC_HIGH_LATCH_MIRROR_IDX;
	endfunction

	// Word index from the byte address
	assign bus_idx   = wb_adr_i[9:2];
	assign bus_req   = wb_cyc_i && wb_stb_i;
	// Writes take effect on the edge where ack is seen high
	assign bus_wr    = bus_req && wb_we_i && ack_q && wb_sel_i[0];
	assign status_wr = bus_wr && is_status(bus_idx);
	assign pcl_wr    = bus_wr && is_pcl(bus_idx);
	assign pc_high_latch_wr = bus_wr && is_pc_high_latch(bus_idx);

	// Read mux; unmapped indexes read as zero
	always_comb begin
		rd_byte = 8'h00;
		if (is_status(bus_idx)) begin
			rd_byte = status_q;
		end else if (is_pcl(bus_idx)) begin
			rd_byte = pc_q[7:0];
		end else if (is_pc_high_latch(bus_idx)) begin
			rd_byte = {3'h0, pc_high_latch_q};
		end
	end

	// One-cycle ack, dropped the cycle after it was given
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req && !ack_q;
		end
	end

	// Read data captured with the ack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 32'h00000000;
		end else if (bus_req && !ack_q) begin
			dat_q <= {24'h000000, rd_byte};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// High latch, untouched by stack traffic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_high_latch_q <= psc_pkg::PC_HIGH_LATCH_RST;
		end else if (pc_high_latch_wr) begin
			pc_high_latch_q <= wb_dat_i[4:0];
		end
	end

	// Any of the three exits pops the stack
	assign any_pop = instr_return || exit_with_literal_instr
		|| interrupt_exit_instr;

	// Counter source by priority; a core reset stops all stack traffic
	always_comb begin
		if (core_reset) begin
			pc_src = psc_pkg::PSC_SRC_HOLD;
		end else if (irq_take) begin
			pc_src = psc_pkg::PSC_SRC_IRQ;
		end else if (instr_call) begin
			pc_src = psc_pkg::PSC_SRC_CALL;
		end else if (direct_jump_instr) begin
			pc_src = psc_pkg::PSC_SRC_JUMP;
		end else if (any_pop) begin
			pc_src = psc_pkg::PSC_SRC_POP;
		end else if (pcl_wr) begin
			pc_src = psc_pkg::PSC_SRC_PCLW;
		end else if (pc_advance) begin
			pc_src = psc_pkg::PSC_SRC_INC;
		end else begin
			pc_src = psc_pkg::PSC_SRC_HOLD;
		end
	end

	// Calls and interrupt entry push the current counter
	assign push = pc_src == psc_pkg::PSC_SRC_IRQ
		|| pc_src == psc_pkg::PSC_SRC_CALL;

	// Next counter value
	always_comb begin
		case (pc_src)
			psc_pkg::PSC_SRC_IRQ: begin
				pc_d = psc_pkg::IRQ_VECTOR;
			end
			psc_pkg::PSC_SRC_CALL, psc_pkg::PSC_SRC_JUMP: begin
				pc_d = {pc_high_latch_q[4:3], jump_addr};
			end
			psc_pkg::PSC_SRC_POP: begin
				pc_d = stack_top;
			end
			psc_pkg::PSC_SRC_PCLW: begin
				pc_d = {pc_high_latch_q, wb_dat_i[7:0]};
			end
			psc_pkg::PSC_SRC_INC: begin
				pc_d = pc_q + 13'h0001;
			end
			default: begin
				pc_d = pc_q;
			end
		endcase
	end

	// Counter register; any reset source clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= psc_pkg::PC_RST;
		end else if (core_reset) begin
			pc_q <= psc_pkg::PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	// Interrupt enable pulses to the interrupt controller
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gie_clr_q <= 1'b0;
			gie_set_q <= 1'b0;
		end else begin
			gie_clr_q <= pc_src == psc_pkg::PSC_SRC_IRQ;
			gie_set_q <= pc_src == psc_pkg::PSC_SRC_POP
				&& interrupt_exit_instr;
		end
	end

	// Hidden return stack; its pointer has no bus access
	psc_ret_stack psc_ret_stack_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (push),
		.pop       (pc_src == psc_pkg::PSC_SRC_POP),
		.push_data (pc_q),
		.top_data  (stack_top)
	);

	// Status flags
	psc_status_reg psc_status_reg_inst (
		.clk         (clk),
		.rst_n       (rst_n),
		.wr_en       (status_wr),
		.wr_data     (wb_dat_i[7:0]),
		.alu_en      (alu_flag_en),
		.alu_sub     (alu_sub),
		.alu_a       (alu_a),
		.alu_b       (alu_b),
		.wdt_kick    (watchdog_kick_instr),
		.halt        (halt_instr),
		.wdt_timeout (watchdog_timeout),
		.status_q    (status_q)
	);

	// Direct address bank selection from the low bank bit
	assign bank_addr = {status_q[psc_pkg::ST_RP0], direct_addr};

	assign pc                    = pc_q;
	assign status                = status_q;
	assign pc_high_latch         = {3'h0, pc_high_latch_q};
	assign global_irq_enable_clr = gie_clr_q;
	assign global_irq_enable_set = gie_set_q;

	a_pcl_write_load: assert property (
		@(posedge clk) disable iff (!rst_n)
		pcl_wr && !core_reset && pc_src == psc_pkg::PSC_SRC_PCLW
		|=> pc_q == {$past(pc_high_latch_q), $past(wb_dat_i[7:0])})
		else $error("low-byte write did not load upper bits from latch");

	a_jump_upper_bits: assert property (
		@(posedge clk) disable iff (!rst_n)
		direct_jump_instr && !irq_take && !instr_call && !core_reset
		|=> pc_q[12:11] == $past(pc_high_latch_q[4:3])
			&& pc_q[10:0] == $past(jump_addr))
		else $error("jump did not combine latch and address field");

	a_irq_vector: assert property (@(posedge clk) disable iff (!rst_n)
		irq_take && !core_reset
		|=> pc_q == psc_pkg::IRQ_VECTOR && global_irq_enable_clr)
		else $error("interrupt entry did not vector or clear enable");

	a_call_return: assert property (
		@(posedge clk) disable iff (!rst_n)
		instr_call && !irq_take && !core_reset ##1
		(instr_return && !irq_take && !instr_call && !direct_jump_instr
			&& !core_reset)
		|=> pc_q == $past(pc_q, 2))
		else $error("return did not restore pushed counter");

	a_exit_enable: assert property (
		@(posedge clk) disable iff (!rst_n)
		interrupt_exit_instr && !irq_take && !instr_call
			&& !direct_jump_instr && !core_reset
		|=> global_irq_enable_set)
		else $error("interrupt exit did not raise the enable pulse");

	a_latch_kept: assert property (
		@(posedge clk) disable iff (!rst_n)
		(push || any_pop) && !pc_high_latch_wr |=> $stable(pc_high_latch_q))
		else $error("stack traffic changed the high latch");

	a_reset_clears: assert property (
		@(posedge clk) disable iff (!rst_n)
		core_reset |=> pc_q == psc_pkg::PC_RST)
		else $error("reset did not clear the counter");

	a_status_mirror: assert property (
		@(posedge clk) disable iff (!rst_n)
		bus_req && !wb_we_i && !ack_q && is_status(bus_idx)
		|=> wb_ack_o && wb_dat_o[7:0] == $past(status_q) ##1 !wb_ack_o)
		else $error("status read at either image returned wrong data");

endmodule

// ==== tb/psc_core_bench.sv ====
// Self-checking bench for the program counter, stack and status core
`timescale 1ns/1ps
module psc_core_bench;
	typedef struct packed {
		logic       sub;
		logic [7:0] a;
		logic [7:0] b;
		logic [2:0] flags;
	} psc_row_type;
	// Event bit positions on the instruction event vector
	localparam logic [11:0] EV_ADV  = 12'h001;
	localparam logic [11:0] EV_CALL = 12'h002;
	localparam logic [11:0] EV_JMP  = 12'h004;
	localparam logic [11:0] EV_RET  = 12'h008;
	localparam logic [11:0] EV_RETL = 12'h010;
	localparam logic [11:0] EV_RETI = 12'h020;
	localparam logic [11:0] EV_IRQ  = 12'h040;
	localparam logic [11:0] EV_KICK = 12'h080;
	localparam logic [11:0] EV_HALT = 12'h100;
	localparam logic [11:0] EV_TMO  = 12'h200;
	localparam logic [11:0] EV_CRST = 12'h400;
	localparam logic [11:0] EV_ALU  = 12'h800;
	// Flag rows: subtract, operands, expected zero, nibble and carry
	localparam psc_row_type ROWS [8] = '{
		'{1'b0, 8'h00, 8'h00, 3'h4}, '{1'b0, 8'h0F, 8'h01, 3'h2},
		'{1'b0, 8'hF0, 8'h10, 3'h5}, '{1'b0, 8'hFF, 8'h01, 3'h7},
		'{1'b1, 8'h05, 8'h03, 3'h3}, '{1'b1, 8'h03, 8'h05, 3'h0},
		'{1'b1, 8'h07, 8'h07, 3'h7}, '{1'b1, 8'h10, 8'h01, 3'h1}};
	logic        clk;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [9:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic [11:0] ev;
	logic [10:0] ja;
	logic        sub;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [6:0]  daddr;
	logic [7:0]  bank_addr;
	logic [12:0] pc;
	logic [7:0]  status;
	logic [7:0]  latch;
	logic        gie_clr;
	logic        gie_set;
	logic [7:0]  rd;
	logic [1:0]  g;
	logic [12:0] pc_e;
	logic [12:0] stk [8];
	int          sp;
	int          error_cnt;
	int          cmp_count;

	psc_core psc_core_inst (
		.clk(clk), .rst_n(rst_n), .core_reset(ev[10]),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pc_advance(ev[0]), .instr_call(ev[1]), .direct_jump_instr(ev[2]),
		.jump_addr(ja), .instr_return(ev[3]),
		.exit_with_literal_instr(ev[4]), .interrupt_exit_instr(ev[5]),
		.irq_take(ev[6]), .alu_flag_en(ev[11]), .alu_sub(sub),
		.alu_a(a), .alu_b(b), .watchdog_kick_instr(ev[7]),
		.halt_instr(ev[8]), .watchdog_timeout(ev[9]),
		.direct_addr(daddr), .bank_addr(bank_addr), .pc(pc),
		.status(status), .pc_high_latch(latch),
		.global_irq_enable_clr(gie_clr), .global_irq_enable_set(gie_set));

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic Wishbone single cycle, waits for ack under a bound
	task automatic wb(input logic w, input logic [9:0] ad,
			input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= {24'h000000, wd};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk(16'h0001, 16'h0000);
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// One-cycle event pulse; gathers interrupt-enable pulses after it
	task automatic fire(input logic [11:0] m, input logic [10:0] j);
		@(posedge clk);
		ev <= m;
		ja <= j;
		@(posedge clk);
		ev <= 12'h000;
		#1;
		g = {gie_set, gie_clr};
		@(posedge clk);
		#1;
		g = g | {gie_set, gie_clr};
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog on the whole run
	initial begin
		#(25 * 4000);
		error_cnt++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{cyc, stb, we, sub, adr, wdat, ev, ja, a, b} = '0;
		daddr = 7'h15;
		error_cnt = 0;
		cmp_count = 0;
		sp = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(16'(pc), 16'h0000);
		chk(16'(status[4:3]), 16'h0003);
		// Arithmetic flag rows
		foreach (ROWS[i]) begin
			@(posedge clk);
			{sub, a, b} <= {ROWS[i].sub, ROWS[i].a, ROWS[i].b};
			fire(EV_ALU, 11'h000);
			chk(16'(status[2:0]), 16'(ROWS[i].flags));
		end
		// Flag-updating write: written low flags overridden
		@(posedge clk);
		{sub, a, b} <= {1'b0, 8'h0F, 8'h01};
		ev <= EV_ALU;
		wb(1'b1, 10'h00C, 8'h27);
		ev <= 12'h000;
		wb(1'b0, 10'h20C, 8'h00);
		chk(16'(rd), 16'h003A);
		chk(16'(bank_addr), 16'h0095);
		wb(1'b1, 10'h20C, 8'h00);
		#1;
		chk(16'(bank_addr), 16'h0015);
		// Reset-cause flags against events and writes
		fire(EV_HALT, 11'h000);
		chk(16'(status[4:3]), 16'h0002);
		wb(1'b1, 10'h00C, 8'h08);
		wb(1'b0, 10'h00C, 8'h00);
		chk(16'(rd[4:3]), 16'h0002);
		fire(EV_TMO, 11'h000);
		chk(16'(status[4:3]), 16'h0000);
		fire(EV_KICK, 11'h000);
		chk(16'(status[4:3]), 16'h0003);
		// Low-byte write loads upper bits from latch
		wb(1'b1, 10'h028, 8'h1F);
		wb(1'b1, 10'h008, 8'hFF);
		#1;
		chk(16'(pc), 16'h1FFF);
		wb(1'b1, 10'h228, 8'h08);
		wb(1'b0, 10'h8A << 2, 8'h00);
		chk(16'(rd), 16'h0008);
		wb(1'b1, 10'h208, 8'h34);
		#1;
		chk(16'(pc), 16'h0834);
		fire(EV_JMP, 11'h7AB);
		chk(16'(pc), 16'h0FAB);
		wb(1'b0, 10'h008, 8'h00);
		chk(16'(rd), 16'h00AB);
		// Nine calls wrap the stack, then nine pops of all kinds
		pc_e = 13'h0FAB;
		for (int i = 0; i < 9; i++) begin
			stk[sp % 8] = pc_e;
			sp++;
			pc_e = {2'b01, 11'(i * 37 + 5)};
			fire(EV_CALL, 11'(i * 37 + 5));
			chk(16'(pc), 16'(pc_e));
		end
		for (int i = 0; i < 9; i++) begin
			sp--;
			pc_e = stk[sp % 8];
			fire(i % 3 == 0 ? EV_RET : (i % 3 == 1 ? EV_RETL : EV_RETI),
				11'h000);
			chk(16'(pc), 16'(pc_e));
		end
		chk(16'(latch), 16'h0008);
		// Interrupt entry and exit
		fire(EV_IRQ, 11'h000);
		chk(16'(pc), 16'h0004);
		chk(16'(g), 16'h0001);
		fire(EV_RETI, 11'h000);
		chk(16'(pc), 16'(pc_e));
		chk(16'(g), 16'h0002);
		chk(16'(latch), 16'h0008);
		// Call and return back to back restore the counter
		@(posedge clk);
		{ev, ja} <= {EV_CALL, 11'h123};
		@(posedge clk);
		ev <= EV_RET;
		fire(12'h000, 11'h000);
		chk(16'(pc), 16'(pc_e));
		// Other reset clears only the counter
		fire(EV_CRST, 11'h000);
		chk(16'(pc), 16'h0000);
		chk(16'(latch), 16'h0008);
		// Unmapped place reads zero
		wb(1'b0, 10'h3FC, 8'h00);
		chk(16'(rd), 16'h0000);
		tally_and_finish();
	end
endmodule
